/* File: src/fpes_sequencer.sv */
// flash program/erase sequencer: factory buffer programming, word program with suspend, erase, status
`timescale 1ns/10ps
`default_nettype none
module fpes_sequencer
  import fpes_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_CYC_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        chip_en_i,
  output logic             standby_o,
  output logic             arr_we_o,
  output fpes_arr_t        arr_o,
  output logic      [7:0]  status_o
);

  typedef enum {
    FPES_IDLE, FPES_WORD_ARG, FPES_F_CONF, FPES_F_SETUP, FPES_F_FILL, FPES_F_PROG,
    FPES_F_EXIT, FPES_E_CONF, FPES_ERASE, FPES_WPROG, FPES_SUSP
  } fpes_state_t;

  localparam int ERASE_W = $clog2(ERASE_CYC + 1);

  fpes_state_t        st_r, st_nxt;
  logic [7:0]         status_r, status_nxt;
  logic [ADDR_W-1:0]  blk_r, blk_nxt;       // address given with the setup command or with the word-program data write
  logic [ADDR_W-1:0]  arr_addr_r, arr_addr_nxt;
  logic [BUF_AW-1:0]  fill_r, fill_nxt;
  logic [BUF_AW:0]    prog_cnt_r, prog_cnt_nxt;
  logic [ERASE_W-1:0] tmr_r, tmr_nxt;
  logic               susp_req_r, susp_req_nxt;
  logic [15:0]        wdata_r, wdata_nxt;
  logic               arr_we_r, arr_we_nxt;
  fpes_arr_t          arr_r, arr_nxt;
  logic               stby_r, stby_nxt;
  logic [15:0]        last_r, last_nxt;
  logic               ce_m_r, ce_s_r;

  logic               wr_stb;
  fpes_wr_t           wr;
  logic [31:0]        ctrl;
  logic               buf_we;
  logic [15:0]        buf_rd;
  logic               supply_ok;
  logic [NBLK-1:0]    lock_bits;

  assign supply_ok = ctrl[CTRL_SUPPLY_OK];
  assign lock_bits = ctrl[CTRL_LOCK_LSB +: NBLK]; // lock bits writable regardless of supply

  // block number of an address
  function automatic logic [ADDR_W-BLK_AW-1:0] blk_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:BLK_AW];
  endfunction

  // next array address, wrapping within the block
  function automatic logic [ADDR_W-1:0] blk_inc(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:BLK_AW], BLK_AW'(a[BLK_AW-1:0] + 1'b1)};
  endfunction

  fpes_wb_slave u_bus (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .wb_cyc_i    (wb_cyc_i),
    .wb_stb_i    (wb_stb_i),
    .wb_we_i     (wb_we_i),
    .wb_adr_i    (wb_adr_i),
    .wb_sel_i    (wb_sel_i),
    .wb_dat_i    (wb_dat_i),
    .wb_dat_o    (wb_dat_o),
    .wb_ack_o    (wb_ack_o),
    .status_i    (status_r),
    .prog_addr_i (arr_addr_r),
    .arr_data_i  (last_r),
    .wr_stb_o    (wr_stb),
    .wr_o        (wr),
    .ctrl_o      (ctrl)
  );

  fpes_word_buf #(
    .DEPTH_LG (BUF_AW)
  ) u_buf (
    .clk_i     (clk_i),
    .we_i      (buf_we),
    .wr_idx_i  (fill_r),
    .wr_data_i (wr.data),
    .rd_idx_i  (prog_cnt_r[BUF_AW-1:0]),
    .rd_data_o (buf_rd)
  );

  // chip enable is a pin: two flops before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ce_m_r <= 1'b1;
      ce_s_r <= 1'b1;
    end else begin
      ce_m_r <= chip_en_i;
      ce_s_r <= ce_m_r;
    end
  end

  // command decode and algorithm sequencing
  always_comb begin
    logic same_blk;
    logic is_rd_cmd;
    same_blk     = blk_of(wr.addr) == blk_of(blk_r);
    is_rd_cmd    = 1'b0;
    st_nxt       = st_r;
    status_nxt   = status_r;
    blk_nxt      = blk_r;
    arr_addr_nxt = arr_addr_r;
    fill_nxt     = fill_r;
    prog_cnt_nxt = prog_cnt_r;
    tmr_nxt      = tmr_r;
    susp_req_nxt = susp_req_r;
    wdata_nxt    = wdata_r;
    arr_we_nxt   = 1'b0;
    arr_nxt      = arr_r;
    buf_we       = 1'b0;
    last_nxt     = last_r;
    // standby only when idle or suspended; erase completes first
    stby_nxt     = ~ce_s_r & (st_r == FPES_IDLE || st_r == FPES_SUSP);
    case (st_r)
      FPES_IDLE: begin
        if (wr_stb) begin
          case (wr.data[7:0])
            CMD_FACTORY_SETUP: begin
              st_nxt  = FPES_F_CONF;
              blk_nxt = wr.addr;
            end
            CMD_ERASE_SETUP: begin
              st_nxt  = FPES_E_CONF;
              blk_nxt = wr.addr;
            end
            CMD_WORD_PROGRAM: st_nxt = FPES_WORD_ARG;
            CMD_CLEAR_STATUS: status_nxt = STATUS_RESET;
            default: ;
          endcase
        end
      end
      FPES_F_CONF: begin
        if (wr_stb) begin
          if (wr.data[7:0] == CMD_CONFIRM && same_blk) begin
            st_nxt                = FPES_F_SETUP;
            status_nxt[ST_READY]  = 1'b0;
            status_nxt[ST_BUF_BUSY] = 1'b1; // buffer closed until the checks pass
            tmr_nxt               = ERASE_W'(SETUP_CYC);
          end else begin
            st_nxt                 = FPES_IDLE;
            status_nxt[ST_PROG_ERR]  = 1'b1;
            status_nxt[ST_ERASE_ERR] = 1'b1;
          end
        end
      end
      FPES_F_SETUP: begin
        // lock, supply and alignment checks after a settling delay
        if (tmr_r != '0) begin
          tmr_nxt = tmr_r - 1'b1;
        end else if (lock_bits[blk_of(blk_r)] | ~supply_ok
                     | (blk_r[BUF_AW-1:0] != '0)) begin
          st_nxt                  = FPES_IDLE;
          status_nxt[ST_READY]    = 1'b1;
          status_nxt[ST_PROG_ERR] = 1'b1;
          status_nxt[ST_BUF_BUSY] = 1'b0;
          status_nxt[ST_LOCK]     = lock_bits[blk_of(blk_r)];
          status_nxt[ST_SUPPLY]   = ~supply_ok;
        end else begin
          st_nxt                   = FPES_F_FILL;
          arr_addr_nxt             = blk_r;
          fill_nxt                 = '0;
          status_nxt[ST_BUF_BUSY]  = 1'b0;
        end
      end
      FPES_F_FILL: begin
        // every in-block write is data, even a read-status code; suspend too is just data
        if (wr_stb) begin
          if (!same_blk) begin
            st_nxt = (wr.data == PAD_WORD) ? FPES_F_EXIT : FPES_IDLE;
            status_nxt[ST_READY] = 1'b1;
            fill_nxt = '0; // partial buffer discarded
          end else begin
            buf_we   = 1'b1;
            fill_nxt = fill_r + 1'b1;
            if (fill_r == '1) begin
              st_nxt                  = FPES_F_PROG;
              prog_cnt_nxt            = '0;
              tmr_nxt                 = '0;
              status_nxt[ST_BUF_BUSY] = 1'b1;
            end
          end
        end
      end
      FPES_F_PROG: begin
        // incoming writes are dropped here
        if (!supply_ok) begin
          st_nxt                  = FPES_IDLE;
          status_nxt[ST_READY]    = 1'b1;
          status_nxt[ST_PROG_ERR] = 1'b1;
          status_nxt[ST_SUPPLY]   = 1'b1;
        end else if (tmr_r != ERASE_W'(WORD_PROG_CYC - 1)) begin
          tmr_nxt = tmr_r + 1'b1;
        end else begin
          tmr_nxt      = '0;
          arr_we_nxt   = 1'b1;
          arr_nxt.addr = arr_addr_r;
          arr_nxt.data = buf_rd;
          last_nxt     = buf_rd;
          arr_addr_nxt = blk_inc(arr_addr_r);
          prog_cnt_nxt = prog_cnt_r + 1'b1;
          if (prog_cnt_r == (BUF_AW+1)'(2**BUF_AW - 1)) begin
            st_nxt                  = FPES_F_FILL;
            fill_nxt                = '0;
            status_nxt[ST_BUF_BUSY] = 1'b0;
          end
        end
      end
      FPES_F_EXIT: begin
        st_nxt = FPES_IDLE;
        status_nxt[ST_BUF_BUSY] = 1'b0;
      end
      FPES_WORD_ARG: begin
        if (wr_stb) begin
          blk_nxt              = wr.addr;
          wdata_nxt            = wr.data;
          status_nxt[ST_READY] = 1'b0;
          tmr_nxt              = '0;
          st_nxt               = FPES_WPROG;
          if (lock_bits[blk_of(wr.addr)] | ~supply_ok) begin
            st_nxt                  = FPES_IDLE;
            status_nxt[ST_READY]    = 1'b1;
            status_nxt[ST_PROG_ERR] = 1'b1;
            status_nxt[ST_LOCK]     = lock_bits[blk_of(wr.addr)];
            status_nxt[ST_SUPPLY]   = ~supply_ok;
          end
        end
      end
      FPES_WPROG: begin
        if (wr_stb && wr.data[7:0] == CMD_PROG_SUSPEND) begin
          susp_req_nxt = 1'b1;
        end
        if (!supply_ok) begin
          st_nxt                  = FPES_IDLE;
          status_nxt[ST_READY]    = 1'b1;
          status_nxt[ST_PROG_ERR] = 1'b1;
          status_nxt[ST_SUPPLY]   = 1'b1;
          susp_req_nxt            = 1'b0;
        end else if (susp_req_r) begin
          // checkpoint: counter freezes here until resume
          st_nxt               = FPES_SUSP;
          susp_req_nxt         = 1'b0;
          status_nxt[ST_READY] = 1'b1;
          status_nxt[ST_SUSP]  = 1'b1;
        end else if (tmr_r < ERASE_W'(WORD_PROG_CYC - 1)) begin
          tmr_nxt = tmr_r + 1'b1;
        end else if (tmr_r == ERASE_W'(WORD_PROG_CYC - 1)) begin
          // word goes out one cycle before ready rises, so ready never shows over a write
          tmr_nxt              = tmr_r + 1'b1;
          arr_we_nxt           = 1'b1;
          arr_nxt.addr         = blk_r;
          arr_nxt.data         = wdata_r;
          last_nxt             = wdata_r;
        end else begin
          st_nxt               = FPES_IDLE;
          status_nxt[ST_READY] = 1'b1;
        end
      end
      FPES_SUSP: begin
        if (wr_stb) begin
          is_rd_cmd = wr.data[7:0] == CMD_READ_ARRAY || wr.data[7:0] == CMD_READ_STATUS
                      || wr.data[7:0] == CMD_READ_ID || wr.data[7:0] == CMD_READ_QUERY;
          if (wr.data[7:0] == CMD_PROG_RESUME) begin
            st_nxt               = FPES_WPROG;
            status_nxt[ST_READY] = 1'b0;
            status_nxt[ST_SUSP]  = 1'b0;
          end else if (!is_rd_cmd) begin
            status_nxt = status_r; // anything else ignored
          end
        end
      end
      FPES_E_CONF: begin
        if (wr_stb) begin
          if (wr.data[7:0] == CMD_CONFIRM && same_blk) begin
            status_nxt[ST_READY] = 1'b0;
            if (lock_bits[blk_of(blk_r)] | ~supply_ok) begin
              st_nxt                = FPES_IDLE;
              status_nxt[ST_READY]  = 1'b1;
              status_nxt[ST_LOCK]   = lock_bits[blk_of(blk_r)];
              status_nxt[ST_SUPPLY] = ~supply_ok;
              status_nxt[ST_ERASE_ERR] = 1'b1;
            end else begin
              st_nxt                  = FPES_ERASE;
              status_nxt[ST_BUF_BUSY] = 1'b1; // block erasing
              tmr_nxt                 = '0;
              arr_addr_nxt            = {blk_r[ADDR_W-1:BLK_AW], BLK_AW'(0)};
            end
          end else begin
            st_nxt                   = FPES_IDLE;
            status_nxt[ST_PROG_ERR]  = 1'b1;
            status_nxt[ST_ERASE_ERR] = 1'b1;
          end
        end
      end
      FPES_ERASE: begin
        // writes each word of the one block to all ones, then waits out the erase time
        if (!supply_ok) begin
          st_nxt                   = FPES_IDLE;
          status_nxt[ST_READY]     = 1'b1;
          status_nxt[ST_BUF_BUSY]  = 1'b0;
          status_nxt[ST_SUPPLY]    = 1'b1;
          status_nxt[ST_ERASE_ERR] = 1'b1;
        end else if (tmr_r < ERASE_W'(2**BLK_AW)) begin
          arr_we_nxt   = 1'b1;
          arr_nxt.addr = arr_addr_r;
          arr_nxt.data = PAD_WORD;
          arr_addr_nxt = blk_inc(arr_addr_r);
          tmr_nxt      = tmr_r + 1'b1;
        end else if (tmr_r < ERASE_W'(ERASE_CYC)) begin
          tmr_nxt = tmr_r + 1'b1;
        end else begin
          st_nxt                  = FPES_IDLE;
          status_nxt[ST_READY]    = 1'b1;
          status_nxt[ST_BUF_BUSY] = 1'b0;
        end
      end
      default: st_nxt = FPES_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r       <= FPES_IDLE;
      status_r   <= STATUS_RESET;
      blk_r      <= '0;
      arr_addr_r <= '0;
      fill_r     <= '0;
      prog_cnt_r <= '0;
      tmr_r      <= '0;
      susp_req_r <= 1'b0;
      wdata_r    <= 16'h0000;
      arr_we_r   <= 1'b0;
      arr_r      <= '0;
      stby_r     <= 1'b0;
      last_r     <= 16'h0000;
    end else begin
      st_r       <= st_nxt;
      status_r   <= status_nxt;
      blk_r      <= blk_nxt;
      arr_addr_r <= arr_addr_nxt;
      fill_r     <= fill_nxt;
      prog_cnt_r <= prog_cnt_nxt;
      tmr_r      <= tmr_nxt;
      susp_req_r <= susp_req_nxt;
      wdata_r    <= wdata_nxt;
      arr_we_r   <= arr_we_nxt;
      arr_r      <= arr_nxt;
      stby_r     <= stby_nxt;
      last_r     <= last_nxt;
    end
  end

  assign standby_o = stby_r;
  assign arr_we_o  = arr_we_r;
  assign arr_o     = arr_r;
  assign status_o  = status_r;

endmodule
`default_nettype wire

/* File: src/fpes_pkg.sv */
// package: command codes, register map, status bit positions, timing for the flash sequencer
package fpes_pkg;

  // command codes on the data lane
  localparam logic [7:0]  CMD_FACTORY_SETUP  = 8'h80;
  localparam logic [7:0]  CMD_CONFIRM        = 8'hd0;
  localparam logic [7:0]  CMD_ERASE_SETUP    = 8'h20;
  localparam logic [7:0]  CMD_PROG_SUSPEND   = 8'hb0;
  localparam logic [7:0]  CMD_PROG_RESUME    = 8'hd0;
  localparam logic [7:0]  CMD_WORD_PROGRAM   = 8'h40;
  localparam logic [7:0]  CMD_READ_ARRAY     = 8'hff;
  localparam logic [7:0]  CMD_READ_STATUS    = 8'h70;
  localparam logic [7:0]  CMD_READ_ID        = 8'h90;
  localparam logic [7:0]  CMD_READ_QUERY     = 8'h98;
  localparam logic [7:0]  CMD_CLEAR_STATUS   = 8'h50;
  localparam logic [15:0] PAD_WORD           = 16'hffff;

  // wishbone register word offsets (byte addresses)
  localparam logic [7:0] REG_CMD     = 8'h00; // w: [15:0] data, launches a bus write
  localparam logic [7:0] REG_ADDR    = 8'h04; // rw: target word address of the next write
  localparam logic [7:0] REG_STATUS  = 8'h08; // r: status flags
  localparam logic [7:0] REG_CTRL    = 8'h0c; // rw: supply ok, block lock bits
  localparam logic [7:0] REG_PROG    = 8'h10; // r: array address counter
  localparam logic [7:0] REG_ARRAY   = 8'h14; // r: last word programmed into the array; erase writes leave it unchanged

  // status bit positions
  localparam int ST_READY     = 7;
  localparam int ST_ERASE_ERR = 5;
  localparam int ST_PROG_ERR  = 4;
  localparam int ST_SUPPLY    = 3;
  localparam int ST_SUSP      = 2;
  localparam int ST_LOCK      = 1;
  localparam int ST_BUF_BUSY  = 0;
  localparam logic [7:0] STATUS_RESET = 8'h80;

  // control register fields
  localparam int CTRL_SUPPLY_OK = 0;
  localparam int CTRL_LOCK_LSB  = 8;

  // geometry
  localparam int ADDR_W  = 16;
  localparam int BUF_AW  = 9;
  localparam int BLK_AW  = 12;
  localparam int NBLK    = 16;

  // timing
  localparam int CLK_MHZ        = 25;
  localparam int SETUP_NS       = 400;
  localparam int SETUP_CYC      = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int WORD_PROG_NS   = 400; // long enough for a suspend written right behind the data
  localparam int WORD_PROG_CYC  = (WORD_PROG_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_US       = 200;
  localparam int ERASE_CYC_DEF  = ERASE_US * CLK_MHZ;

  // one bus write toward the command decoder
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0]       data;
  } fpes_wr_t;

  // one array write from the sequencer
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0]       data;
  } fpes_arr_t;

endpackage

/* File: src/fpes_wb_slave.sv */
// wishbone classic slave: register decode, write launch and read mux
`timescale 1ns/10ps
`default_nettype none
module fpes_wb_slave
  import fpes_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  status_i,
  input  wire logic [ADDR_W-1:0] prog_addr_i,
  input  wire logic [15:0] arr_data_i,
  output logic             wr_stb_o,
  output fpes_wr_t         wr_o,
  output logic      [31:0] ctrl_o
);

  logic        ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic        stb_r, stb_nxt;
  fpes_wr_t    wr_r, wr_nxt;

  // byte-lane merge for writable registers
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // one answer per request, ack dropped the cycle after it was given
  always_comb begin
    logic req;
    req      = wb_cyc_i & wb_stb_i & ~ack_r;
    ack_nxt  = req;
    dat_nxt  = dat_r;
    addr_nxt = addr_r;
    ctrl_nxt = ctrl_r;
    stb_nxt  = 1'b0;
    wr_nxt   = wr_r;
    if (req & wb_we_i) begin
      case (wb_adr_i)
        REG_CMD: begin
          if (wb_sel_i[0] | wb_sel_i[1]) begin
            stb_nxt     = 1'b1;
            wr_nxt.addr = addr_r;
            wr_nxt.data = wb_dat_i[15:0];
          end
        end
        REG_ADDR: addr_nxt = ADDR_W'(lane_merge(32'(addr_r), wb_dat_i, wb_sel_i));
        REG_CTRL: ctrl_nxt = lane_merge(ctrl_r, wb_dat_i, wb_sel_i);
        default:  ;
      endcase
    end
    if (req & ~wb_we_i) begin
      case (wb_adr_i)
        REG_ADDR:   dat_nxt = 32'(addr_r);
        REG_STATUS: dat_nxt = {24'h000000, status_i};
        REG_CTRL:   dat_nxt = ctrl_r;
        REG_PROG:   dat_nxt = 32'(prog_addr_i);
        REG_ARRAY:  dat_nxt = {16'h0000, arr_data_i};
        default:    dat_nxt = 32'h00000000; // unmapped reads zero, still acked
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      dat_r  <= 32'h00000000;
      addr_r <= '0;
      ctrl_r <= 32'h00000001; // supply ok, all blocks unlocked
      stb_r  <= 1'b0;
      wr_r   <= '0;
    end else begin
      ack_r  <= ack_nxt;
      dat_r  <= dat_nxt;
      addr_r <= addr_nxt;
      ctrl_r <= ctrl_nxt;
      stb_r  <= stb_nxt;
      wr_r   <= wr_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign wr_stb_o = stb_r;
  assign wr_o     = wr_r;
  assign ctrl_o   = ctrl_r;

endmodule
`default_nettype wire

/* File: src/fpes_word_buf.sv */
// write buffer: flip-flop storage indexed by position
`timescale 1ns/10ps
`default_nettype none
module fpes_word_buf
  import fpes_pkg::*;
#(
  parameter int DEPTH_LG = BUF_AW
) (
  input  wire logic                clk_i,
  input  wire logic                we_i,
  input  wire logic [DEPTH_LG-1:0] wr_idx_i,
  input  wire logic [15:0]         wr_data_i,
  input  wire logic [DEPTH_LG-1:0] rd_idx_i,
  output logic      [15:0]         rd_data_o
);

  logic [15:0] mem_r [2**DEPTH_LG];

  // contents need no reset: every slot is written before it is read
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[wr_idx_i] <= wr_data_i;
    end
  end

  assign rd_data_o = mem_r[rd_idx_i];

endmodule
`default_nettype wire

/* File: sim/fpes_sequencer_sva.sv */
// checker: port timing of the flash sequencer
`timescale 1ns/10ps
`default_nettype none
module fpes_sequencer_sva
  import fpes_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       standby_o,
  input wire logic       arr_we_o,
  input wire logic [7:0] status_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence susp_s; status_o[ST_SUSP][*2]; endsequence
  sequence erasing_s; (status_o[ST_BUF_BUSY] && !status_o[ST_READY])[*2]; endsequence
  // bus answer comes one cycle after the request and lasts one cycle
  ack_next_a: assert property (req_s |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  reset_val_a: assert property (disable iff (1'b0) rst_i |=> status_o == STATUS_RESET)
    else $error("reset status");
  // ready stays low while the array is written; suspension reads ready and halts
  arr_busy_a: assert property (arr_we_o |-> !status_o[ST_READY])
    else $error("busy");
  susp_ready_a: assert property (susp_s |-> status_o[ST_READY])
    else $error("susp");
  susp_halt_a: assert property (susp_s |-> !arr_we_o)
    else $error("susp write");
  // a running erase keeps the part out of standby
  erase_stby_a: assert property (erasing_s |-> !standby_o)
    else $error("stby");
  stby_ready_a: assert property (standby_o[*2] |-> status_o[ST_READY])
    else $error("stby");
endmodule
bind fpes_sequencer fpes_sequencer_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .standby_o, .arr_we_o, .status_o);
`default_nettype wire

/* File: sim/fpes_host_model.sv */
// host model: wishbone master issuing single register cycles
`timescale 1ns/10ps
`default_nettype none
module fpes_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o = 1'b0,
  output logic             we_o = 1'b0,
  output logic      [7:0]  adr_o = 8'h00,
  output logic      [31:0] dat_o = 32'h0
);
  // request held until ack is sampled; data lane inverted once released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    cyc_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = dat_i;
    cyc_o <= 1'b0;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* File: sim/tb_flash_program_erase_sequencer.sv */
// bench: random and corner traffic through the sequencer registers
`timescale 1ns/10ps
`default_nettype none
module tb_flash_program_erase_sequencer;
  import fpes_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc, we, ack, aw, sb, ce = 1'b1;
  logic [7:0] adr, st;
  logic [31:0] wd, rdat, q;
  fpes_arr_t arr;
  int n_mismatch = 0, num_checks = 0, n_arr = 0, n_cyc = 0, a0;
  always #20 clk_i = ~clk_i;
  fpes_host_model u_host (.clk_i, .cyc_o(cyc), .we_o(we), .adr_o(adr), .dat_o(wd),
    .ack_i(ack), .dat_i(rdat));
  fpes_sequencer #(.ERASE_CYC(4200)) u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rdat),
    .wb_ack_o(ack), .chip_en_i(ce), .standby_o(sb), .arr_we_o(aw), .arr_o(arr), .status_o(st));
  // array write count and watchdog; a hang counts as a mismatch
  always @(posedge clk_i) begin
    n_arr <= n_arr + int'(aw === 1'b1);
    n_cyc <= n_cyc + 1;
    if (n_cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0, q);
  endtask
  // poll status until ready and buffer flag reach the wanted pair
  task automatic poll(input logic [1:0] rb);
    rd(REG_STATUS);
    while ({q[7], q[0]} !== rb) rd(REG_STATUS);
  endtask
  task automatic setup(input logic [31:0] a, input logic [31:0] c);
    wr(REG_ADDR, a);
    wr(REG_CMD, c);
    wr(REG_CMD, 32'hd0);
  endtask
  // status expected after a refused factory setup
  function automatic logic [31:0] err(input logic lk, input logic sup);
    return {24'h0, 4'h9, ~sup, 1'b0, lk, 1'b0};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // word program in block 3, suspended by a command right behind the data
  task automatic wsusp(input logic [31:0] d);
    wr(REG_CMD, 32'h50);
    wr(REG_ADDR, 32'h3000);
    wr(REG_CMD, 32'h40);
    wr(REG_CMD, d);
    wr(REG_CMD, 32'hb0);
    rd(REG_STATUS);
    chk("suspended", 32'h84, q);
  endtask
  initial begin
    void'($urandom(64052));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(REG_CTRL);
    chk("ctrl", 32'h1, q);
    rd(8'h1c);
    chk("unmapped", 32'h0, q);
    // two full buffers into block 1; command codes in the stream are plain data
    setup(32'h1000, 32'h80);
    for (int b = 0; b < 2; b++) begin
      poll(2'b00);
      for (int i = 0; i < 512; i++)
        wr(REG_CMD, (i == 511) ? {16'h0, PAD_WORD} : (i == 0) ? 32'hb0
          : (i == 1) ? 32'h70 : {16'h0, 16'($urandom)});
      rd(REG_STATUS);
      chk("busy", 32'h1, {31'h0, q[0]});
      chk("no suspend", 32'h0, {31'h0, q[2]});
      wr(REG_CMD, 32'h1234);
    end
    poll(2'b00);
    rd(REG_ARRAY);
    chk("last word", {16'h0, PAD_WORD}, q);
    rd(REG_PROG);
    chk("next address", 32'h1400, q);
    chk("arr count", 1024, n_arr);
    wr(REG_ADDR, 32'h2000);
    wr(REG_CMD, {16'h0, PAD_WORD});
    poll(2'b10);
    chk("exit", 32'h80, q);
    // partial fill abandoned by an out-of-block address
    a0 = n_arr;
    setup(32'h1000, 32'h80);
    poll(2'b00);
    wr(REG_CMD, 32'h5a5a);
    wr(REG_ADDR, 32'h5000);
    wr(REG_CMD, 32'h1234);
    poll(2'b10);
    chk("discard", a0, n_arr);
    $display("factory test done");
    // refused setups: unaligned start, locked block, supply low
    for (int k = 0; k < 3; k++) begin
      wr(REG_CTRL, (k == 1) ? 32'h201 : 32'(k == 0));
      setup((k == 0) ? 32'h1004 : 32'h1000, 32'h80);
      poll(2'b10);
      chk("refused", err(k == 1, k < 2), q);
      wr(REG_CMD, 32'h50);
    end
    $display("refusal test done");
    // erase block 4 with chip enable dropped, then a locked erase
    wr(REG_CTRL, 32'h1);
    a0 = n_arr;
    setup(32'h4000, 32'h20);
    ce <= 1'b0;
    rd(REG_STATUS);
    chk("erasing", 32'h1, {30'h0, q[7], q[0]});
    poll(2'b10);
    chk("erased", 32'h80, q);
    chk("erase count", a0 + 4096, n_arr);
    chk("standby", 32'h1, {31'h0, sb});
    ce <= 1'b1;
    wr(REG_CTRL, 32'h1001);
    setup(32'h4000, 32'h20);
    poll(2'b10);
    chk("locked", 32'ha2, q);
    $display("erase test done");
    // word program suspended, held in standby, then resumed
    a0 = n_arr;
    wsusp(32'habcd);
    ce <= 1'b0;
    wr(REG_CMD, 32'h40);
    rd(REG_STATUS);
    chk("held", 32'h84, q);
    chk("susp standby", 32'h1, {31'h0, sb});
    chk("susp writes", a0, n_arr);
    ce <= 1'b1;
    rd(REG_STATUS);
    wr(REG_CMD, 32'hd0);
    rd(REG_STATUS);
    chk("resumed", 32'h0, q);
    poll(2'b10);
    rd(REG_ARRAY);
    chk("resumed word", 32'habcd, q);
    // reset pin while suspended
    wsusp(32'h1357);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(REG_STATUS);
    chk("reset status", 32'h80, q);
    rd(REG_CTRL);
    chk("reset ctrl", 32'h1, q);
    $display("suspend test done");
    results();
  end
endmodule
`default_nettype wire
